// ---- hdl/axf_fifo_top.sv ----
// Purpose: AXI channel queue with first-word fall-through output
// Assumes: One clock for both ports; AXI sides are same-clock logic
// Notes: Change channel mode only while the queue is empty
// Contract
// - Oldest word sits on the output with valid, no read request needed.
// - Ready follows full, almost-full or prog-full; valid follows empty variants.
// - Channel acts as full queue, one register slice, or a plain wire.
// - Queue variants: data, packet, and reduced-latency data.
// - Write and read words share one width, the sum of channel signals.
// - Depth is a power of two from 16 to 131072; any other depth is only flagged in status.
// - Stream and full data channels default to 1024 words.
// - Error injection and checking exist only for block memory.
// - Prog-full asserts once occupancy reaches its threshold.
// - Prog-empty asserts while occupancy is at or below its threshold.
// - Occupancy count reports stored words, log2(depth)+1 bits wide.
// - Common clock gives one count for both ports.
// - Overflow and underflow flags are offered for both memory kinds.
// - In full-queue mode, a read on empty raises underflow and leaves state untouched.
// - Write on full raises overflow, drops the word, leaves state untouched.
// - Write side and read side handshakes are timed on their clock.
`timescale 1ns/1ps
`default_nettype none

module axf_fifo_top
  import axf_pkg::*;
(
  input wire logic sys_clk_in, // 125 MHz clock
  input wire logic rst_b_in, // Async reset, active low
  // AHB-Lite register slave
  input wire logic hsel_in, // Slave select
  input wire logic [31:0] haddr_in, // Byte address
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic hwrite_in, // Write when high
  input wire logic [2:0] hsize_in, // Transfer size
  input wire logic hready_in, // Bus ready
  input wire logic [31:0] hwdata_in, // Write data
  output logic [31:0] hrdata_out, // Read data
  output logic hreadyout_out, // Always ready
  output logic hresp_out, // Always OKAY
  // Write side, from upstream master
  input wire logic s_valid_in, // Word offered
  input wire axf_word_t s_data_in, // Offered word
  output logic s_ready_out, // Word accepted this cycle
  // Read side, toward downstream slave
  output logic m_valid_out, // Word on output
  output axf_word_t m_data_out, // Oldest word
  input wire logic m_ready_in, // Downstream takes word
  // Status
  output logic [CNT_W-1:0] data_count_out, // Stored words
  output logic overflow_out, // Write refused on full
  output logic underflow_out, // Read attempted on empty
  output logic irq_out // Unmasked event pending
);

  // Register state
  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0] pfull_q;
  logic [CNT_W-1:0] pempty_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [31:0] hrdata_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q;

  // Queue state
  logic [WORD_W:0] mem_q [DEPTH]; // Same word type both ports, plus parity
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CNT_W-1:0] occ_q;
  logic [CNT_W-1:0] pkt_q;
  logic ov_q;
  axf_word_t od_q;
  logic ovf_q;
  logic udf_q;

  // Decoded control
  logic [1:0] mode;
  logic [1:0] app;
  logic [1:0] rdy_src;
  logic [1:0] vld_src;
  logic ecc_on;
  logic inj_on;
  assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
  assign app = ctrl_q[CTRL_APP_LSB +: 2];
  assign rdy_src = ctrl_q[CTRL_RDY_LSB +: 2];
  assign vld_src = ctrl_q[CTRL_VLD_LSB +: 2];
  // Checking is tied off unless backed by block memory
  assign ecc_on = MEM_BLOCK && ctrl_q[CTRL_ECC_EN];
  assign inj_on = MEM_BLOCK && ctrl_q[CTRL_ECC_INJ];

  // Occupancy flags; out stage counts as stored
  logic full;
  logic empty;
  logic afull;
  logic aempty;
  logic pfull;
  logic pempty;
  logic [CNT_W-1:0] mem_cnt;
  assign full = (occ_q == CNT_W'(DEPTH));
  assign empty = (occ_q == '0);
  assign afull = (occ_q >= CNT_W'(DEPTH - 1));
  assign aempty = (occ_q <= CNT_W'(1));
  assign pfull = (occ_q >= pfull_q);
  assign pempty = (occ_q <= pempty_q);
  assign mem_cnt = occ_q - CNT_W'(ov_q);

  // Write-side ready source; full always stops writes
  logic rdy_block;
  always_comb
  begin
    unique case (rdy_src)
      SRC_ALMOST: rdy_block = afull;
      SRC_PROG: rdy_block = pfull;
      default: rdy_block = full;
    endcase
  end

  // Read-side valid gate; packet variant waits for a whole packet
  logic vld_gate;
  always_comb
  begin
    if (app == APP_PACKET)
      vld_gate = (pkt_q != '0);
    else
    begin
      unique case (vld_src)
        SRC_ALMOST: vld_gate = !aempty;
        SRC_PROG: vld_gate = !pempty;
        default: vld_gate = !empty;
      endcase
    end
  end

  // Handshakes per channel configuration
  logic fifo_m;
  logic slice_m;
  logic pass_m;
  logic wr_ok;
  logic rd_ok;
  assign fifo_m = (mode == MODE_FIFO);
  assign slice_m = (mode == MODE_SLICE);
  assign pass_m = !fifo_m && !slice_m;
  always_comb
  begin
    if (pass_m)
    begin
      s_ready_out = m_ready_in;
      m_valid_out = s_valid_in;
      m_data_out = s_data_in;
    end
    else if (slice_m)
    begin
      s_ready_out = !ov_q || m_ready_in;
      m_valid_out = ov_q;
      m_data_out = od_q;
    end
    else
    begin
      s_ready_out = !full && !rdy_block;
      m_valid_out = ov_q && vld_gate;
      m_data_out = od_q;
    end
  end
  // Transfer only on valid and ready together
  assign wr_ok = !pass_m && s_valid_in && s_ready_out;
  assign rd_ok = !pass_m && m_valid_out && m_ready_in;

  // Out stage refill decisions
  logic stage_free;
  logic load_mem;
  logic load_dir;
  logic wr_mem;
  assign stage_free = !ov_q || rd_ok;
  assign load_mem = fifo_m && stage_free && (mem_cnt != '0);
  // Low-latency variant skips the memory when nothing is queued ahead
  assign load_dir = wr_ok && stage_free && (slice_m
    || (app == APP_LOWLAT && mem_cnt == '0));
  assign wr_mem = wr_ok && !load_dir;

  // Memory word with a parity bit; injection corrupts the stored parity
  logic [WORD_W:0] wr_word;
  logic [WORD_W:0] rd_word;
  logic ecc_err;
  assign wr_word = {(^s_data_in) ^ inj_on, s_data_in};
  assign rd_word = mem_q[rp_q];
  assign ecc_err = load_mem && ecc_on && (^rd_word);

  // Storage array, no reset needed on data
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_mem)
      mem_q[wp_q] <= wr_word;
  end

  // Pointers move only on real transfers, never on refused ones
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (wr_mem)
        wp_q <= wp_q + AW'(1);
      if (load_mem)
        rp_q <= rp_q + AW'(1);
    end
  end

  // Output stage holding the oldest word
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ov_q <= 1'b0;
      od_q <= '0;
    end
    else if (load_mem)
    begin
      ov_q <= 1'b1;
      od_q <= rd_word[WORD_W-1:0];
    end
    else if (load_dir)
    begin
      ov_q <= 1'b1;
      od_q <= s_data_in;
    end
    else if (rd_ok)
      ov_q <= 1'b0;
  end

  // Occupancy and stored packet ends
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      occ_q <= '0;
      pkt_q <= '0;
    end
    else
    begin
      occ_q <= occ_q + CNT_W'(wr_ok) - CNT_W'(rd_ok);
      pkt_q <= pkt_q + CNT_W'(wr_ok && s_data_in.tlast)
        - CNT_W'(rd_ok && od_q.tlast);
    end
  end
  // One count only: both ports run on sys_clk_in, so nothing crosses
  assign data_count_out = occ_q;

  // Refused accesses: state is left alone, only a flag is raised
  logic ovf_ev;
  logic udf_ev;
  assign ovf_ev = fifo_m && s_valid_in && full;
  assign udf_ev = fifo_m && m_ready_in && empty;
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ovf_q <= 1'b0;
      udf_q <= 1'b0;
    end
    else
    begin
      ovf_q <= ovf_ev;
      udf_q <= udf_ev;
    end
  end
  assign overflow_out = ovf_q;
  assign underflow_out = udf_q;

  // AHB address phase capture
  logic ap_take;
  assign ap_take = hsel_in && htrans_in[1] && hready_in;
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= '0;
    end
    else if (hready_in)
    begin
      ap_wr_q <= ap_take && hwrite_in;
      ap_addr_q <= haddr_in[7:0];
    end
  end

  // Read mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    unique case (haddr_in[7:0])
      REG_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
      REG_PFULL: rd_mux[CNT_W-1:0] = pfull_q;
      REG_PEMPTY: rd_mux[CNT_W-1:0] = pempty_q;
      REG_STATUS:
      begin
        rd_mux[CNT_W-1:0] = occ_q;
        rd_mux[ST_FULL] = full;
        rd_mux[ST_EMPTY] = empty;
        rd_mux[ST_PFULL] = pfull;
        rd_mux[ST_PEMPTY] = pempty;
        rd_mux[ST_DEPTH_OK] = DEPTH_OK;
      end
      REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
      REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      default: rd_mux = '0;
    endcase
  end

  // Read data is sampled at the address phase, zero wait states
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      hrdata_q <= '0;
    else if (ap_take && !hwrite_in)
      hrdata_q <= rd_mux;
  end
  assign hrdata_out = hrdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // Writable configuration registers
  logic wr_ctrl;
  logic wr_pf;
  logic wr_pe;
  logic wr_mask;
  logic wr_stat;
  assign wr_ctrl = ap_wr_q && (ap_addr_q == REG_CTRL);
  assign wr_pf = ap_wr_q && (ap_addr_q == REG_PFULL);
  assign wr_pe = ap_wr_q && (ap_addr_q == REG_PEMPTY);
  assign wr_mask = ap_wr_q && (ap_addr_q == REG_IRQ_MASK);
  assign wr_stat = ap_wr_q && (ap_addr_q == REG_IRQ_STAT);
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_q <= CTRL_RST;
      pfull_q <= PFULL_RST;
      pempty_q <= PEMPTY_RST;
      irq_mask_q <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= hwdata_in[CTRL_W-1:0];
      if (wr_pf)
        pfull_q <= hwdata_in[CNT_W-1:0];
      if (wr_pe)
        pempty_q <= hwdata_in[CNT_W-1:0];
      if (wr_mask)
        irq_mask_q <= hwdata_in[IRQ_W-1:0];
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_ev = {ecc_err, udf_ev, ovf_ev};
  assign irq_clr = wr_stat ? hwdata_in[IRQ_W-1:0] : '0;
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
  end
  assign irq_out = |(irq_stat_q & irq_mask_q);

endmodule : axf_fifo_top

`default_nettype wire

// ---- hdl/axf_pkg.sv ----
// Purpose: Shared constants and types for the AXI channel FWFT queue
// Assumes: One clock, AHB-Lite register access, 32-bit data bus
// Notes: Depth and widths fixed; depth legality is reported, not trapped
package axf_pkg;

  // Stream word carried through the queue
  localparam int TDATA_W = 32;
  localparam int TKEEP_W = TDATA_W / 8;
  localparam int TUSER_W = 4;
  typedef struct packed {
    logic [TDATA_W-1:0] tdata;
    logic [TKEEP_W-1:0] tkeep;
    logic [TUSER_W-1:0] tuser;
    logic tlast;
  } axf_word_t;
  localparam int WORD_W = $bits(axf_word_t);

  // Depth: stream and full-profile data channels default to 1024
  localparam int DEPTH = 1024;
  localparam int DEPTH_MIN = 16;
  localparam int DEPTH_MAX = 131072;
  localparam int AW = $clog2(DEPTH);
  localparam int CNT_W = AW + 1;
  localparam bit DEPTH_OK = (DEPTH >= DEPTH_MIN) && (DEPTH <= DEPTH_MAX)
    && ((DEPTH & (DEPTH - 1)) == 0);
  localparam bit MEM_BLOCK = 1'b1;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PFULL = 8'h04;
  localparam logic [7:0] REG_PEMPTY = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_APP_LSB = 2;
  localparam int CTRL_RDY_LSB = 4;
  localparam int CTRL_VLD_LSB = 6;
  localparam int CTRL_ECC_EN = 8;
  localparam int CTRL_ECC_INJ = 9;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  // Channel configuration and application variants
  localparam logic [1:0] MODE_FIFO = 2'h0;
  localparam logic [1:0] MODE_SLICE = 2'h1;
  localparam logic [1:0] MODE_PASS = 2'h2;
  localparam logic [1:0] APP_DATA = 2'h0;
  localparam logic [1:0] APP_PACKET = 2'h1;
  localparam logic [1:0] APP_LOWLAT = 2'h2;

  // Ready and valid generation sources
  localparam logic [1:0] SRC_PLAIN = 2'h0;
  localparam logic [1:0] SRC_ALMOST = 2'h1;
  localparam logic [1:0] SRC_PROG = 2'h2;

  // Threshold reset values
  localparam logic [CNT_W-1:0] PFULL_RST = CNT_W'(DEPTH / 2);
  localparam logic [CNT_W-1:0] PEMPTY_RST = CNT_W'(2);

  // Status field positions
  localparam int ST_FULL = 24;
  localparam int ST_EMPTY = 25;
  localparam int ST_PFULL = 26;
  localparam int ST_PEMPTY = 27;
  localparam int ST_DEPTH_OK = 28;

  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_UDF = 1;
  localparam int IRQ_ECC = 2;

endpackage : axf_pkg

// ---- tb/axf_checker.sv ----
// Purpose: Port-level checks for the channel queue
// Assumes: One clock domain, bound onto axf_fifo_top
// Notes: Mode is not visible here, so checks key on the count
`timescale 1ns/1ps
`default_nettype none
module axf_checker
  import axf_pkg::*;
(
  input wire logic sys_clk_in, // Clock
  input wire logic rst_b_in, // Reset, active low
  input wire logic hsel_in, // Slave select
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic hwrite_in, // Write flag
  input wire logic hready_in, // Bus ready
  input wire logic [31:0] hrdata_out, // Read data
  input wire logic hreadyout_out, // Slave ready
  input wire logic hresp_out, // Response
  input wire logic s_valid_in, // Write valid
  input wire logic s_ready_out, // Write ready
  input wire logic m_valid_out, // Read valid
  input wire axf_word_t m_data_out, // Read word
  input wire logic m_ready_in, // Read ready
  input wire logic [CNT_W-1:0] data_count_out, // Occupancy
  input wire logic overflow_out, // Overflow pulse
  input wire logic underflow_out // Underflow pulse
);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Bus side never stalls or errors
  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus wait or error response");
  a_rdata_hold: assert property (
    !(hsel_in && htrans_in[1] && hready_in && !hwrite_in) |=> $stable(hrdata_out))
    else $error("read data moved without a read");
  // Full refuses, flags and keeps its state
  a_full_noready: assert property (data_count_out == FULL_CNT |-> !s_ready_out)
    else $error("ready while full");
  a_ovf_full: assert property (
    s_valid_in && data_count_out == FULL_CNT |=> overflow_out)
    else $error("no overflow on full write");
  a_ovf_cause: assert property (
    overflow_out |-> $past(s_valid_in && data_count_out == FULL_CNT))
    else $error("overflow without cause");
  a_ovf_keep: assert property (
    s_valid_in && data_count_out == FULL_CNT && !m_ready_in |=> data_count_out == FULL_CNT)
    else $error("full state changed by refused write");
  // Underflow only from a read on empty
  a_udf_cause: assert property (
    underflow_out |-> $past(m_ready_in && data_count_out == 0))
    else $error("underflow without cause");
  // Output held until taken, nothing shown when empty
  a_out_hold: assert property (
    m_valid_out && !m_ready_in |=> m_valid_out && $stable(m_data_out))
    else $error("output dropped before taken");
  a_empty_idle: assert property (
    data_count_out == 0 && !s_valid_in |-> !m_valid_out)
    else $error("valid while empty");
  a_count_step: assert property (
    data_count_out == $past(data_count_out) || data_count_out == $past(data_count_out) + 1'b1
    || data_count_out + 1'b1 == $past(data_count_out))
    else $error("count jumped");
  c_ovf: cover property (overflow_out);
  c_udf: cover property (underflow_out);
  c_full: cover property (data_count_out == FULL_CNT);
endmodule : axf_checker
`default_nettype wire

// ---- tb/axf_partner.sv ----
// Purpose: Upstream source and downstream sink for the queue
// Assumes: Same clock as the queue
// Notes: Released data shows the inverse so stale words never match
`timescale 1ns/1ps
`default_nettype none
module axf_partner
  import axf_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic s_ready_in, // Queue accepts
  input wire logic m_valid_in, // Queue offers
  input wire axf_word_t m_data_in, // Offered word
  input wire logic take_in, // Sink willing
  output logic s_valid_out, // Source valid
  output axf_word_t s_data_out, // Source word
  output logic m_ready_out // Sink ready
);
  axf_word_t got [$];
  initial
  begin
    s_valid_out = 1'b0;
    s_data_out = '0;
  end
  // Sink stalls whenever the bench withholds take
  assign m_ready_out = take_in;
  // Capture on handshake edges only
  always @(posedge clk_in)
    if (m_valid_in && m_ready_out) got.push_back(m_data_in);
  // Hold word until accepted, unless a one-shot attempt
  task push(input axf_word_t w, input bit hold);
    @(posedge clk_in);
    s_valid_out <= 1'b1;
    s_data_out <= w;
    do @(posedge clk_in); while (hold && s_ready_in !== 1'b1);
    s_valid_out <= 1'b0;
    s_data_out <= ~w;
  endtask : push
endmodule : axf_partner
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Register and stream tests of the channel queue
// Assumes: Depth 1024 from the package, single clock
// Notes: Fills to full once, so the run is a few thousand cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import axf_pkg::*;
;
  logic sys_clk_in, rst_b_in, hsel, hwrite, hready, take, s_valid, s_ready, m_valid, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic m_ready;
  axf_word_t s_data, m_data;
  logic [CNT_W-1:0] cnt;
  int mismatches, tests_run;
  int mode_tab [5] = '{0, 4, 8, 1, 2};
  axf_fifo_top i_axf_fifo_top (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(), .s_valid_in(s_valid), .s_data_in(s_data), .s_ready_out(s_ready),
    .m_valid_out(m_valid), .m_data_out(m_data), .m_ready_in(m_ready),
    .data_count_out(cnt), .overflow_out(), .underflow_out(), .irq_out(irq));
  axf_partner i_axf_partner (.clk_in(sys_clk_in), .s_ready_in(s_ready), .m_valid_in(m_valid),
    .m_data_in(m_data), .take_in(take), .s_valid_out(s_valid), .s_data_out(s_data),
    .m_ready_out(m_ready));
  // Free-running clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  function automatic axf_word_t mkw(input int k);
    mkw = {32'hA5000000 + 32'(k), 4'hF, 4'(k), 1'b1};
  endfunction : mkw
  task check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One AHB transfer: address phase, then data phase
  task ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge sys_clk_in);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task wait_got(input int n);
    for (int i = 0; i < 3000 && i_axf_partner.got.size() < n; i++) @(posedge sys_clk_in);
  endtask : wait_got
  task stop_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // Watchdog against a hung handshake
  initial
  begin
    #400000;
    mismatches++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    {hsel, hwrite, take, haddr, hwdata, htrans, rst_b_in} = '0;
    repeat (4) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    ahb(REG_CTRL, 0, 0); check(rd, 0);
    ahb(REG_PFULL, 0, 0); check(rd, 32'h200);
    ahb(REG_PEMPTY, 0, 0); check(rd, 32'h2);
    ahb(REG_STATUS, 0, 0); check(rd, 32'h1A000000);
    ahb(8'h20, 1, 32'hFFFFFFFF); ahb(8'h20, 0, 0); check(rd, 0);
    // Every channel mode and queue variant passes words in order
    take <= 1'b1;
    foreach (mode_tab[i])
    begin
      ahb(REG_CTRL, 1, mode_tab[i]);
      i_axf_partner.got.delete();
      for (int j = 0; j < 3; j++) i_axf_partner.push(mkw(10 * i + j), 1);
      wait_got(3);
      for (int j = 0; j < 3; j++) check(i_axf_partner.got[j], mkw(10 * i + j));
    end
    ahb(REG_CTRL, 1, 0);
    ahb(REG_PFULL, 1, 4);
    // Prog-full ready and prog-empty valid gates, then the almost gates
    ahb(REG_CTRL, 1, 32'hA0);
    take <= 1'b0;
    i_axf_partner.got.delete();
    for (int k = 0; k < 4; k++)
    begin
      i_axf_partner.push(mkw(100 + k), 1);
      @(negedge sys_clk_in);
      check(m_valid, k >= 2);
      check(s_ready, k < 3);
    end
    ahb(REG_CTRL, 1, 32'h50); @(negedge sys_clk_in);
    check({m_valid, s_ready}, 2'h3);
    // Parity check flags a word stored with injected error, data kept
    ahb(REG_CTRL, 1, 32'h300);
    i_axf_partner.push(mkw(104), 1);
    ahb(REG_CTRL, 1, 32'h100);
    take <= 1'b1;
    wait_got(5);
    for (int k = 0; k < 5; k++) check(i_axf_partner.got[k], mkw(100 + k));
    ahb(REG_IRQ_STAT, 0, 0); check(rd, 32'h6);
    // Sink stalled first, so no new underflow lands after the clear
    take <= 1'b0;
    ahb(REG_IRQ_STAT, 1, 7);
    ahb(REG_CTRL, 1, 0);
    // Fill with the sink stalled, watching thresholds
    take <= 1'b0;
    i_axf_partner.got.delete();
    for (int k = 0; k < DEPTH; k++)
    begin
      i_axf_partner.push(mkw(k), 1);
      if (k < 4) ahb(REG_STATUS, 0, 0);
      if (k < 4) check(rd, 32'(k + 1) | 32'(k >= 3) << 26 | 32'(k < 2) << 27 | 1 << 28);
    end
    @(negedge sys_clk_in); check(cnt, DEPTH);
    check(s_ready, 0);
    i_axf_partner.push(mkw(2000), 0);
    @(negedge sys_clk_in); check(cnt, DEPTH);
    ahb(REG_IRQ_STAT, 0, 0); check(rd, 32'h1);
    check(irq, 0);
    ahb(REG_IRQ_MASK, 1, 7); @(negedge sys_clk_in); check(irq, 1);
    ahb(REG_IRQ_STAT, 1, 1); @(negedge sys_clk_in); check(irq, 0);
    // Drain in order; the refused word must not appear
    take <= 1'b1;
    wait_got(DEPTH + 1);
    check(i_axf_partner.got.size(), DEPTH);
    for (int k = 0; k < DEPTH; k++) check(i_axf_partner.got[k], mkw(k));
    ahb(REG_IRQ_STAT, 0, 0); check(rd, 32'h2);
    check(irq, 1);
    take <= 1'b0;
    ahb(REG_IRQ_STAT, 1, 2); ahb(REG_IRQ_STAT, 0, 0); check(rd, 0);
    // Queue still sound after underflow
    i_axf_partner.got.delete();
    i_axf_partner.push(mkw(3000), 1);
    take <= 1'b1;
    wait_got(1);
    check(i_axf_partner.got[0], mkw(3000));
    stop_test();
  end
endmodule : tb_top
bind axf_fifo_top axf_checker i_axf_checker (.sys_clk_in, .rst_b_in, .hsel_in, .htrans_in,
  .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .s_valid_in, .s_ready_out,
  .m_valid_out, .m_data_out, .m_ready_in, .data_count_out, .overflow_out, .underflow_out);
`default_nettype wire
